// file: core/rhbg_pkg.sv
package rhbg_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int TD_MIN_PS      = 240000;
	localparam int TD_MAX_PS      = 1650000;
	localparam int TRST_MAX_US    = 5;
	// Least time rounds up, longest rounds down
	localparam int TD_MIN_CYC     = (TD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TD_MAX_CYC_RAW = TD_MAX_PS / CLK_PERIOD_PS;
	localparam int TD_MAX_CYC     = (TD_MAX_CYC_RAW < 1) ? 1 : TD_MAX_CYC_RAW;
	localparam int TRST_MAX_CYC   = (TRST_MAX_US * 1000 * 1000) / CLK_PERIOD_PS;

	localparam int CNT_W          = 16;
	localparam int ACC_W          = 16;
	localparam logic [CNT_W-1:0] TD_MIN   = CNT_W'(TD_MIN_CYC);
	localparam logic [CNT_W-1:0] TD_MAX   = CNT_W'(TD_MAX_CYC);
	localparam logic [CNT_W-1:0] TRST_MAX = CNT_W'(TRST_MAX_CYC);
	// Accumulator step for a capacitive-mode event (low charge rate)
	localparam logic [ACC_W-1:0] ACC_LOW_STEP  = 16'h0011;
	localparam logic [ACC_W-1:0] ACC_TRIP_DFLT = 16'h1000;
	localparam logic [ACC_W-1:0] ACC_RST       = 16'h0000;

	typedef enum logic [2:0] {
		RHBG_IDLE,
		RHBG_DT_TO_HI,
		RHBG_HI_ON,
		RHBG_DT_TO_LO,
		RHBG_LO_ON,
		RHBG_TRIPPED
	} rhbg_state_t;

endpackage

// file: core/rhbg_sync.sv
`timescale 1ns/100ps
`default_nettype none
module rhbg_sync
	import rhbg_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         mclk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_r;

	// Two-stage synchroniser, one per bit
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge mclk_i) begin
				if (!rst_b_i) begin
					meta_r[g] <= 1'b0;
					sync_o[g] <= 1'b0;
				end else begin
					meta_r[g] <= async_i[g];
					sync_o[g] <= meta_r[g];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// file: core/rhbg_core.sv
`timescale 1ns/100ps
`default_nettype none
module rhbg_core
	import rhbg_pkg::*;
(
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_b_i,
	// Enable comparators
	input  wire logic             supply_start_ok_i,
	input  wire logic             input_sense_ok_i,
	input  wire logic             feedback_ok_i,
	// Dead-time select comparator (high = at or above select_threshold)
	input  wire logic             dead_time_select_pin_i,
	// Midpoint slew comparators
	input  wire logic             midpoint_high_i,
	input  wire logic             midpoint_low_i,
	// Resonant current comparators
	input  wire logic             rc_above_pos_i,
	input  wire logic             rc_below_neg_i,
	input  wire logic             rc_reset_reached_i,
	input  wire logic             heavy_load_i,
	// Period control from frequency loop
	input  wire logic             switch_req_i,
	input  wire logic             startup_i,
	input  wire logic [ACC_W-1:0] accumulator_trip_level_i,
	// Drives and status
	output logic                  gate_high_o,
	output logic                  gate_low_o,
	output logic                  cap_level_b_sel_o,
	output logic                  cap_detect_o,
	output logic                  auto_dead_time_o,
	output logic [CNT_W-1:0]      dead_time_o,
	output logic [ACC_W-1:0]      overload_accumulator_node_o,
	output logic                  overload_latch_o
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [9:0] raw_w;
	logic [9:0] syn_w;
	assign raw_w = {supply_start_ok_i, input_sense_ok_i, feedback_ok_i,
		dead_time_select_pin_i, midpoint_high_i, midpoint_low_i,
		rc_above_pos_i, rc_below_neg_i, rc_reset_reached_i, heavy_load_i};

	rhbg_sync #(.W(10)) u_sync (
		.mclk_i  (mclk_i),
		.rst_b_i (rst_b_i),
		.async_i (raw_w),
		.sync_o  (syn_w)
	);

	wire vcc_ok    = syn_w[9];
	wire vsen_ok   = syn_w[8];
	wire fb_ok     = syn_w[7];
	wire sel_high  = syn_w[6];
	wire mid_high  = syn_w[5];
	wire mid_low   = syn_w[4];
	wire rc_pos    = syn_w[3];
	wire rc_neg    = syn_w[2];
	wire rc_rst    = syn_w[1];
	wire heavy     = syn_w[0];

	// ****************************************
	// State and registers
	// ****************************************
	rhbg_state_t      state_r, state_nxt;
	logic             mode_fixed_r;
	logic             mode_taken_r;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] slew_r;
	logic             slew_run_r;
	logic [CNT_W-1:0] dt_r;
	logic [ACC_W-1:0] acc_r;
	logic             olp_r;
	logic             rc_pos_d_r;
	logic             rc_neg_d_r;
	logic             cap_r;

	function automatic logic [CNT_W-1:0] clamp_dt(input logic [CNT_W-1:0] v);
		if (v < TD_MIN)
			return TD_MIN;
		else if (v > TD_MAX)
			return TD_MAX;
		else
			return v;
	endfunction

	// ****************************************
	// Decoding
	// ****************************************
	wire run_ok     = vcc_ok && vsen_ok && fb_ok;
	wire hard_reset = !vcc_ok || !vsen_ok;
	wire cap_hi     = (state_r == RHBG_HI_ON) && rc_pos_d_r && !rc_pos;
	wire cap_lo     = (state_r == RHBG_LO_ON) && rc_neg_d_r && !rc_neg;
	wire cap_evt    = cap_hi || cap_lo;
	wire reset_ok   = rc_rst || (cnt_r >= TRST_MAX);
	wire end_req    = (switch_req_i && !startup_i) || startup_i;
	wire on_done    = cap_evt || (end_req && reset_ok);
	wire mid_slewing = !mid_high && !mid_low;
	wire dt_arrived = (state_r == RHBG_DT_TO_HI) ? mid_high : mid_low;
	// Auto mode: dead time ends once the midpoint reaches the far rail inside the window, or at TD_MAX; fixed mode ends at TD_MIN
	wire dt_done    = mode_fixed_r ? (cnt_r >= TD_MIN)
		: ((cnt_r >= TD_MIN && dt_arrived) || cnt_r >= TD_MAX);
	wire [ACC_W:0] acc_sum = {1'b0, acc_r} + {1'b0, ACC_LOW_STEP};
	wire acc_trip   = acc_r >= accumulator_trip_level_i;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			RHBG_IDLE:     if (run_ok) state_nxt = RHBG_DT_TO_LO;
			RHBG_DT_TO_HI: if (dt_done) state_nxt = RHBG_HI_ON;
			RHBG_HI_ON:    if (on_done) state_nxt = RHBG_DT_TO_LO;
			RHBG_DT_TO_LO: if (dt_done) state_nxt = RHBG_LO_ON;
			RHBG_LO_ON:    if (on_done) state_nxt = RHBG_DT_TO_HI;
			RHBG_TRIPPED:  state_nxt = RHBG_TRIPPED;
		endcase
		if (olp_r || acc_trip)
			state_nxt = RHBG_TRIPPED;
		else if (!run_ok)
			state_nxt = RHBG_IDLE;
		if (hard_reset)
			state_nxt = RHBG_IDLE;
	end

	wire state_chg = state_nxt != state_r;

	// ****************************************
	// Sequencing
	// ****************************************
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			state_r <= RHBG_IDLE;
			cnt_r   <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= state_chg ? '0 : cnt_r + 1'b1;
		end
	end

	// Mode caught once when the supply start condition is met
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			mode_fixed_r <= 1'b0;
			mode_taken_r <= 1'b0;
		end else if (!vcc_ok) begin
			mode_taken_r <= 1'b0;
		end else if (!mode_taken_r) begin
			mode_fixed_r <= sel_high;
			mode_taken_r <= 1'b1;
		end
	end

	// ****************************************
	// Dead-time measurement
	// ****************************************
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			slew_r     <= '0;
			slew_run_r <= 1'b0;
			dt_r       <= TD_MIN;
		end else begin
			slew_run_r <= mid_slewing;
			if (mid_slewing)
				slew_r <= slew_run_r ? slew_r + 1'b1 : CNT_W'(1);
			else if (slew_run_r && !mode_fixed_r)
				dt_r <= clamp_dt(slew_r);
			if (mode_fixed_r)
				dt_r <= TD_MIN;
		end
	end

	// ****************************************
	// Capacitive mode and overload
	// ****************************************
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			rc_pos_d_r <= 1'b0;
			rc_neg_d_r <= 1'b0;
			cap_r      <= 1'b0;
			acc_r      <= ACC_RST;
			olp_r      <= 1'b0;
		end else begin
			rc_pos_d_r <= rc_pos;
			rc_neg_d_r <= rc_neg;
			cap_r      <= cap_evt;
			if (hard_reset) begin
				acc_r <= ACC_RST;
				olp_r <= 1'b0;
			end else begin
				if (cap_evt)
					acc_r <= acc_sum[ACC_W] ? '1 : acc_sum[ACC_W-1:0];
				if (acc_trip)
					olp_r <= 1'b1;
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i) begin
			gate_high_o <= 1'b0;
			gate_low_o  <= 1'b0;
		end else begin
			gate_high_o <= state_nxt == RHBG_HI_ON;
			gate_low_o  <= state_nxt == RHBG_LO_ON;
		end
	end

	assign cap_level_b_sel_o           = heavy;
	assign cap_detect_o                = cap_r;
	assign auto_dead_time_o            = !mode_fixed_r;
	assign dead_time_o                 = dt_r;
	assign overload_accumulator_node_o = acc_r;
	assign overload_latch_o            = olp_r;

endmodule
`default_nettype wire

// file: sim/rhbg_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module rhbg_monitor
	import rhbg_pkg::*;
(
	// Clock and reset
	input wire logic             mclk_i,
	input wire logic             rst_b_i,
	// Inputs
	input wire logic             supply_start_ok_i,
	input wire logic             input_sense_ok_i,
	input wire logic             rc_above_pos_i,
	input wire logic             rc_below_neg_i,
	input wire logic [ACC_W-1:0] accumulator_trip_level_i,
	// Outputs
	input wire logic             gate_high_o,
	input wire logic             gate_low_o,
	input wire logic             cap_detect_o,
	input wire logic             auto_dead_time_o,
	input wire logic [CNT_W-1:0] dead_time_o,
	input wire logic [ACC_W-1:0] overload_accumulator_node_o,
	input wire logic             overload_latch_o
);
	localparam int TD_LO = TD_MIN_CYC;
	localparam int TD_HI = TD_MAX_CYC;
	logic [10:0] off_r;
	logic [10:0] on_r;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	// ******
	// Both-off run and high-side on-time
	// ******
	always_ff @(posedge mclk_i) begin
		if (!rst_b_i || gate_high_o || gate_low_o) off_r <= 11'h000;
		else if (off_r != 11'h7FF) off_r <= off_r + 11'h001;
		if (!rst_b_i || !gate_high_o) on_r <= 11'h000;
		else if (on_r != 11'h7FF) on_r <= on_r + 11'h001;
	end
	a_both_off: assert property (!(gate_high_o && gate_low_o))
		else $error("gates overlap");
	a_dead_gap: assert property ($rose(gate_high_o) || $rose(gate_low_o) |-> off_r >= TD_LO)
		else $error("dead time short");
	a_dead_range: assert property (auto_dead_time_o && ($rose(gate_high_o) || $rose(gate_low_o))
		|-> dead_time_o >= TD_LO && dead_time_o <= TD_HI) else $error("dead time out of window");
	a_cap_high: assert property ($fell(rc_above_pos_i) && gate_high_o |-> ##[1:4] !gate_high_o)
		else $error("high side kept on");
	a_cap_low: assert property ($fell(rc_below_neg_i) && gate_low_o |-> ##[1:4] !gate_low_o)
		else $error("low side kept on");
	a_acc_step: assert property ($changed(overload_accumulator_node_o)
		&& overload_accumulator_node_o != ACC_RST |-> overload_accumulator_node_o
		== $past(overload_accumulator_node_o) + ACC_LOW_STEP) else $error("accumulator step");
	a_trip_latch: assert property (supply_start_ok_i && input_sense_ok_i
		&& overload_accumulator_node_o >= accumulator_trip_level_i |-> ##[0:3] overload_latch_o)
		else $error("overload not latched");
	a_latch_off: assert property (overload_latch_o |=> !gate_high_o && !gate_low_o)
		else $error("drive while latched");
	a_reset_max: assert property (on_r <= 11'h3EB)
		else $error("on-period too long");
	cover property (cap_detect_o);
	cover property ($rose(overload_latch_o));
	cover property (on_r == 11'h3E7);
endmodule
bind rhbg_core rhbg_monitor mon (.mclk_i, .rst_b_i, .supply_start_ok_i, .input_sense_ok_i,
	.rc_above_pos_i, .rc_below_neg_i, .accumulator_trip_level_i, .gate_high_o, .gate_low_o,
	.cap_detect_o, .auto_dead_time_o, .dead_time_o, .overload_accumulator_node_o,
	.overload_latch_o);
`default_nettype wire

// file: sim/rhbg_stage.sv
`timescale 1ns/100ps
`default_nettype none
module rhbg_stage (
	// Clock
	input  wire logic       mclk_i,
	// Gate drives and slew time in cycles
	input  wire logic       gate_high_i,
	input  wire logic       gate_low_i,
	input  wire logic [8:0] slew_i,
	// Midpoint rail comparators
	output logic            midpoint_high_o,
	output logic            midpoint_low_o
);
	logic [8:0] cnt_r = 9'h000;
	logic       rise_r = 1'b0;
	// Midpoint leaves its rail when a switch opens and reaches the other after slew_i
	always_ff @(posedge mclk_i) begin
		if (gate_high_i || gate_low_i) begin
			cnt_r <= 9'h000;
			rise_r <= gate_low_i;
		end else if (cnt_r != 9'h1FF) begin
			cnt_r <= cnt_r + 9'h001;
		end
	end
	assign midpoint_high_o = gate_high_i || (rise_r && cnt_r >= slew_i);
	assign midpoint_low_o  = gate_low_i || (!rise_r && cnt_r >= slew_i);
endmodule
`default_nettype wire

// file: sim/test_resonant_half_bridge_guard.sv
`timescale 1ns/100ps
`default_nettype none
module test_resonant_half_bridge_guard;
	import rhbg_pkg::*;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic supply_start_ok_i, input_sense_ok_i, feedback_ok_i, dead_time_select_pin_i;
	logic midpoint_high_i, midpoint_low_i, rc_above_pos_i, rc_below_neg_i, rc_reset_reached_i;
	logic heavy_load_i, switch_req_i, startup_i, gate_high_o, gate_low_o, cap_level_b_sel_o;
	logic cap_detect_o, auto_dead_time_o, overload_latch_o;
	logic [ACC_W-1:0] accumulator_trip_level_i, overload_accumulator_node_o;
	logic [CNT_W-1:0] dead_time_o;
	logic [8:0] slew;
	int err_count, n_checks, n;
	rhbg_core dut (.mclk_i, .rst_b_i, .supply_start_ok_i, .input_sense_ok_i, .feedback_ok_i,
		.dead_time_select_pin_i, .midpoint_high_i, .midpoint_low_i, .rc_above_pos_i,
		.rc_below_neg_i, .rc_reset_reached_i, .heavy_load_i, .switch_req_i, .startup_i,
		.accumulator_trip_level_i, .gate_high_o, .gate_low_o, .cap_level_b_sel_o, .cap_detect_o,
		.auto_dead_time_o, .dead_time_o, .overload_accumulator_node_o, .overload_latch_o);
	rhbg_stage stage (.mclk_i, .gate_high_i(gate_high_o), .gate_low_i(gate_low_o), .slew_i(slew),
		.midpoint_high_o(midpoint_high_i), .midpoint_low_o(midpoint_low_i));
	initial forever #2.5 mclk_i = ~mclk_i;
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(string nm, int lo, int hi, logic [15:0] got);
		n_checks++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			err_count++;
			$display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask
	task automatic cyc(int k);
		repeat (k) @(negedge mclk_i);
	endtask
	task automatic gw(logic hi, logic lvl);
		for (n = 0; (hi ? gate_high_o : gate_low_o) !== lvl; n++) begin
			if (n == 3000) begin
				err_count++;
				$display("[FAIL] gate wait expected %0b seen timeout", lvl);
				end_of_test;
			end
			@(negedge mclk_i);
		end
	endtask
	task automatic per(int k);
		repeat (k) begin
			gw(1, 1);
			gw(0, 1);
		end
	endtask
	task automatic cap(logic hi);
		logic [15:0] a;
		gw(hi, 1);
		cyc(5);
		if (hi) rc_above_pos_i = 1'b1;
		else rc_below_neg_i = 1'b1;
		cyc(5);
		a = overload_accumulator_node_o;
		rc_above_pos_i = 1'b0;
		rc_below_neg_i = 1'b0;
		gw(hi, 0);
		chk("swap", 1, 4, n);
		chk("cap pulse", 1, 1, cap_detect_o);
		cyc(3);
		chk("acc step", a + 17, a + 17, overload_accumulator_node_o);
	endtask
	task automatic t_start;
		supply_start_ok_i = 1'b1;
		input_sense_ok_i = 1'b1;
		cyc(60);
		chk("idle gates", 0, 0, {gate_high_o, gate_low_o});
		chk("auto mode", 1, 1, auto_dead_time_o);
		chk("level a", 0, 0, cap_level_b_sel_o);
		feedback_ok_i = 1'b1;
		gw(0, 1);
		per(3);
		chk("dead time", 56, 66, dead_time_o);
		gw(0, 0);
		gw(1, 1);
		chk("gap", 56, 68, n);
		slew = 9'h014;
		per(3);
		chk("clamp low", 48, 48, dead_time_o);
		slew = 9'h190;
		per(3);
		chk("clamp high", 330, 330, dead_time_o);
		slew = 9'h03C;
		$display("t_start done");
	endtask
	task automatic t_reset;
		rc_reset_reached_i = 1'b0;
		gw(1, 1);
		gw(1, 0);
		chk("on limit", 1000, 1003, n);
		switch_req_i = 1'b0;
		startup_i = 1'b1;
		gw(0, 1);
		cyc(50);
		chk("held on", 1, 1, gate_low_o);
		rc_reset_reached_i = 1'b1;
		gw(0, 0);
		chk("release", 1, 5, n);
		startup_i = 1'b0;
		$display("t_reset done");
	endtask
	task automatic t_cap;
		heavy_load_i = 1'b1;
		cyc(4);
		chk("level b", 1, 1, cap_level_b_sel_o);
		cap(1);
		cap(0);
		accumulator_trip_level_i = overload_accumulator_node_o + 16'h0011;
		cap(1);
		chk("latch", 1, 1, overload_latch_o);
		switch_req_i = 1'b1;
		cyc(20);
		chk("latched gates", 0, 0, {gate_high_o, gate_low_o, ~overload_latch_o});
		input_sense_ok_i = 1'b0;
		cyc(6);
		chk("latch clear", 0, 0, overload_latch_o);
		chk("acc clear", 0, 0, overload_accumulator_node_o);
		$display("t_cap done");
	endtask
	task automatic t_fixed;
		supply_start_ok_i = 1'b0;
		dead_time_select_pin_i = 1'b1;
		cyc(10);
		supply_start_ok_i = 1'b1;
		input_sense_ok_i = 1'b1;
		cyc(70);
		dead_time_select_pin_i = 1'b0;
		cyc(10);
		chk("fixed mode", 0, 0, auto_dead_time_o);
		per(2);
		gw(0, 0);
		gw(1, 1);
		chk("fixed gap", 48, 51, n);
		$display("t_fixed done");
	endtask
	initial begin
		{supply_start_ok_i, input_sense_ok_i, feedback_ok_i, dead_time_select_pin_i} = 4'h0;
		{rc_above_pos_i, rc_below_neg_i, heavy_load_i, startup_i} = 4'h0;
		{rc_reset_reached_i, switch_req_i} = 2'h3;
		accumulator_trip_level_i = 16'h1000;
		slew = 9'h03C;
		err_count = 0;
		n_checks = 0;
		cyc(10);
		rst_b_i = 1'b1;
		t_start;
		t_reset;
		t_cap;
		t_fixed;
		end_of_test;
	end
endmodule
`default_nettype wire
